// ==== pkg/rccd_pkg.sv ====
`default_nettype none
package rccd_pkg;

	////////////////////////////////////////////////////////////////////////
	// Data path widths
	localparam int DATA_W    = 16;
	localparam int RS_ORDER  = 2;
	localparam int F5_ORDER  = 5;
	// Second-order growth: log2(4096^2) = 24 bits
	localparam int RS_ACC_W  = DATA_W + 24;
	// Fifth-order growth: 5 * log2(32) = 25 bits
	localparam int F5_ACC_W  = DATA_W + 25;
	localparam int BUF_DEPTH = 2;

	////////////////////////////////////////////////////////////////////////
	// Register bus
	localparam int ADDR_W = 10;
	localparam int IDX_W  = 8;
	localparam int BUS_W  = 32;
	localparam logic [IDX_W-1:0] IDX_RS_DEC    = 8'h90;
	localparam logic [IDX_W-1:0] IDX_RS_INT    = 8'h91;
	localparam logic [IDX_W-1:0] IDX_RS_SCALE  = 8'h92;
	localparam logic [IDX_W-1:0] IDX_F5_DEC    = 8'h93;
	localparam logic [IDX_W-1:0] IDX_F5_SCALE  = 8'h94;
	localparam logic [IDX_W-1:0] IDX_STATUS    = 8'h95;

	////////////////////////////////////////////////////////////////////////
	// Field layouts
	localparam int RS_DEC_W     = 12;
	localparam int RS_INT_W     = 9;
	localparam int RS_SCALE_W   = 10;
	localparam int SCALE_W      = 5;
	localparam int SCALE_HI_LSB = 5;
	localparam int F5_DEC_W     = 5;
	localparam int SHIFT_W      = 6;

	////////////////////////////////////////////////////////////////////////
	// Reset values and limits
	localparam logic [RS_DEC_W-1:0]   RS_DEC_RST    = 12'h000;
	localparam logic [RS_INT_W-1:0]   RS_INT_RST    = 9'h000;
	localparam logic [RS_SCALE_W-1:0] RS_SCALE_RST  = 10'h000;
	localparam logic [F5_DEC_W-1:0]   F5_DEC_RST    = 5'h01;
	localparam logic [F5_DEC_W-1:0]   F5_DEC_MIN_M1 = 5'h01;
	localparam logic [SCALE_W-1:0]    F5_SCALE_RST  = 5'h00;
	localparam logic [SCALE_W-1:0]    F5_SCALE_MAX  = 5'h14;
	localparam logic [SHIFT_W-1:0]    F5_NORM       = 6'h05;

	typedef enum {RS_IDLE, RS_STUFF} rccd_rs_state_t;

endpackage
`default_nettype wire

// ==== hdl/rccd_comb_core.sv ====
`timescale 1ns/10ps
`default_nettype none
module rccd_comb_core #(
	parameter int ORDER = rccd_pkg::F5_ORDER,
	parameter int W     = rccd_pkg::F5_ACC_W
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// Sequencing strobes
	input  wire logic         advance,
	input  wire logic         integ_en,
	input  wire logic         dump_en,
	// Samples
	input  wire logic [W-1:0] in_data,
	output logic              res_valid,
	output logic      [W-1:0] res_data
);

	typedef struct packed {
		logic [ORDER-1:0][W-1:0] acc;
		logic [ORDER-1:0][W-1:0] dly;
		logic [W-1:0]            res;
		logic                    valid;
	} rccd_core_t;

	rccd_core_t r;
	rccd_core_t next_r;

	////////////////////////////////////////////////////////////////////////
	// Wraparound arithmetic is intended: combs cancel integrator overflow
	always_comb
	begin
		logic [W-1:0] x;
		x = '0;
		next_r = r;
		if (advance)
		begin
			next_r.valid = dump_en;
			if (integ_en)
			begin
				next_r.acc[0] = r.acc[0] + in_data;
				for (int k = 1; k < ORDER; k++)
				begin
					next_r.acc[k] = r.acc[k] + r.acc[k-1];
				end
			end
			if (dump_en)
			begin
				x = r.acc[ORDER-1];
				for (int k = 0; k < ORDER; k++)
				begin
					next_r.dly[k] = x;
					x = x - r.dly[k];
				end
				next_r.res = x;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			r <= '0;
		else
			r <= next_r;
	end

	assign res_valid = r.valid;
	assign res_data  = r.res;

endmodule
`default_nettype wire

// ==== hdl/rccd_pair_buf.sv ====
`timescale 1ns/10ps
`default_nettype none
module rccd_pair_buf #(
	parameter int W     = 2 * rccd_pkg::DATA_W,
	parameter int DEPTH = rccd_pkg::BUF_DEPTH
) (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst_b,
	// Filling side
	input  wire logic                       in_valid,
	output logic                            in_ready,
	input  wire logic [W-1:0]               in_data,
	// Draining side
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic      [W-1:0]               out_data,
	// Fill level
	output logic      [$clog2(DEPTH+1)-1:0] level
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0]           wr;
		logic [PW-1:0]           rd;
		logic [CW-1:0]           cnt;
	} rccd_buf_t;

	rccd_buf_t r;
	rccd_buf_t next_r;
	logic      push;
	logic      pop;

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign in_ready  = (r.cnt != CW'(DEPTH));
	assign out_valid = (r.cnt != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_comb
	begin
		next_r = r;
		if (push)
		begin
			next_r.mem[r.wr] = in_data;
			next_r.wr = bump(r.wr);
		end
		if (pop)
			next_r.rd = bump(r.rd);
		if (push && !pop)
			next_r.cnt = r.cnt + 1'b1;
		else if (pop && !push)
			next_r.cnt = r.cnt - 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			r <= '0;
		else
			r <= next_r;
	end

	assign out_data = r.mem[r.rd];
	assign level    = r.cnt;

endmodule
`default_nettype wire

// ==== hdl/rccd_top.sv ====
// What this block does
// - 12-bit decimation-minus-one register at resample_decimation
// - 9-bit interpolation-minus-one register at resample_interpolation
// - Scale bits 9:5 give 6 dB steps
// - Ratio 1/1 passes unfiltered, still scaled
// - Gain is M squared over L, 2^S
// - Fifth-stage decimation 2 through 32
// - Five sections, delay M, normalise 2^(S+5)
// - Fifth-stage scale 0 to 20, 6 dB
// - One output per decimation-count inputs
// - Accept fifth-stage input up to 65 MHz
// - Zero-stuff by L, second-order decimate M
// - Interpolation 1..512, decimation 1..4096
`timescale 1ns/10ps
`default_nettype none
module rccd_top #(
	parameter int DATA_W = rccd_pkg::DATA_W
) (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst_b,
	// Avalon-MM slave
	input  wire logic [rccd_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire logic [rccd_pkg::BUS_W-1:0]  avs_writedata,
	input  wire logic [3:0]                  avs_byteenable,
	output logic      [rccd_pkg::BUS_W-1:0]  avs_readdata,
	output logic                             avs_waitrequest,
	// Upstream complex samples
	input  wire logic                        in_valid,
	output logic                             in_ready,
	input  wire logic [DATA_W-1:0]           in_i,
	input  wire logic [DATA_W-1:0]           in_q,
	// Downstream complex samples
	output logic                             out_valid,
	input  wire logic                        out_ready,
	output logic      [DATA_W-1:0]           out_i,
	output logic      [DATA_W-1:0]           out_q
);

	localparam int RS_ACC_W = rccd_pkg::RS_ACC_W;
	localparam int F5_ACC_W = rccd_pkg::F5_ACC_W;
	localparam int BW       = rccd_pkg::BUS_W;
	localparam int LW       = $clog2(rccd_pkg::BUF_DEPTH + 1);
	localparam logic signed [F5_ACC_W-1:0] SAT_HI = {{(F5_ACC_W-DATA_W+1){1'b0}}, {(DATA_W-1){1'b1}}};
	localparam logic signed [F5_ACC_W-1:0] SAT_LO = ~SAT_HI;

	typedef struct packed {
		logic [rccd_pkg::RS_DEC_W-1:0]   rs_dec;
		logic [rccd_pkg::RS_INT_W-1:0]   rs_int;
		logic [rccd_pkg::RS_SCALE_W-1:0] rs_scale;
		logic [rccd_pkg::F5_DEC_W-1:0]   f5_dec;
		logic [rccd_pkg::SCALE_W-1:0]    f5_scale;
		logic                            ack;
		logic [BW-1:0]                   rdata;
		rccd_pkg::rccd_rs_state_t        rs_state;
		logic [rccd_pkg::RS_INT_W-1:0]   stuff_cnt;
		logic [rccd_pkg::RS_DEC_W-1:0]   rs_mcnt;
		logic [rccd_pkg::F5_DEC_W-1:0]   f5_mcnt;
		logic                            byp_valid;
		logic [DATA_W-1:0]               byp_i;
		logic [DATA_W-1:0]               byp_q;
		logic                            s1_valid;
		logic [DATA_W-1:0]               s1_i;
		logic [DATA_W-1:0]               s1_q;
	} rccd_main_t;

	rccd_main_t r;
	rccd_main_t next_r;

	////////////////////////////////////////////////////////////////////////
	// Shared helpers

	// Arithmetic shift then clamp to the sample width
	function automatic logic [DATA_W-1:0] shift_sat(input logic signed [F5_ACC_W-1:0] x,
		input logic [rccd_pkg::SHIFT_W-1:0] sh);
		logic signed [F5_ACC_W-1:0] y;
		y = x >>> sh;
		if (y > SAT_HI)
			shift_sat = {1'b0, {(DATA_W-1){1'b1}}};
		else if (y < SAT_LO)
			shift_sat = {1'b1, {(DATA_W-1){1'b0}}};
		else
			shift_sat = y[DATA_W-1:0];
	endfunction

	function automatic logic [BW-1:0] be_merge(input logic [BW-1:0] old, input logic [BW-1:0] wd,
		input logic [3:0] be);
		be_merge = old;
		for (int b = 0; b < 4; b++)
		begin
			if (be[b])
				be_merge[b*8 +: 8] = wd[b*8 +: 8];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Interconnect

	logic                    go;
	logic                    bypass;
	logic                    accept;
	logic                    rs_integ;
	logic                    rs_dump;
	logic [RS_ACC_W-1:0]     rs_in_i;
	logic [RS_ACC_W-1:0]     rs_in_q;
	logic                    rs_res_valid;
	logic                    rs_res_valid_q;
	logic [RS_ACC_W-1:0]     rs_res_i;
	logic [RS_ACC_W-1:0]     rs_res_q;
	logic                    f5_integ;
	logic                    f5_dump;
	logic [F5_ACC_W-1:0]     f5_in_i;
	logic [F5_ACC_W-1:0]     f5_in_q;
	logic                    f5_res_valid;
	logic                    f5_res_valid_q;
	logic [F5_ACC_W-1:0]     f5_res_i;
	logic [F5_ACC_W-1:0]     f5_res_q;
	logic [rccd_pkg::F5_DEC_W-1:0] f5_dec_eff;
	logic [rccd_pkg::SCALE_W-1:0]  f5_scale_eff;
	logic [rccd_pkg::SHIFT_W-1:0]  f5_shift;
	logic [rccd_pkg::SHIFT_W-1:0]  rs_shift;
	logic                    push;
	logic [2*DATA_W-1:0]     push_data;
	logic                    buf_in_ready;
	logic [2*DATA_W-1:0]     buf_out_data;
	logic [LW-1:0]           buf_level;
	logic [rccd_pkg::IDX_W-1:0] idx;
	logic                    wr_fire;
	logic                    factor_wr;
	logic [BW-1:0]           rd_mux;

	// Whole pipeline freezes while the output buffer is full, so nothing in flight is dropped
	assign go     = buf_in_ready;
	assign bypass = (r.rs_dec == '0) && (r.rs_int == '0);
	// Full clock rate in bypass, far above 65 MHz; stuffing holds input off for L-1 cycles
	assign in_ready = go && (r.rs_state == rccd_pkg::RS_IDLE);
	assign accept   = in_valid && in_ready;

	assign rs_integ = go && !bypass && (accept || (r.rs_state == rccd_pkg::RS_STUFF));
	assign rs_dump  = rs_integ && (r.rs_mcnt == r.rs_dec);
	// Stuffed phases feed zeros, which gives the 1/L term of the gain
	assign rs_in_i  = accept ? {{(RS_ACC_W-DATA_W){in_i[DATA_W-1]}}, in_i} : '0;
	assign rs_in_q  = accept ? {{(RS_ACC_W-DATA_W){in_q[DATA_W-1]}}, in_q} : '0;

	assign rs_res_valid_q = rs_res_valid;
	assign rs_shift = {1'b0, r.rs_scale[rccd_pkg::SCALE_HI_LSB +: rccd_pkg::SCALE_W]};

	assign f5_dec_eff   = (r.f5_dec < rccd_pkg::F5_DEC_MIN_M1) ? rccd_pkg::F5_DEC_MIN_M1 : r.f5_dec;
	assign f5_scale_eff = (r.f5_scale > rccd_pkg::F5_SCALE_MAX) ? rccd_pkg::F5_SCALE_MAX : r.f5_scale;
	assign f5_shift     = {1'b0, f5_scale_eff} + rccd_pkg::F5_NORM;
	assign f5_integ = go && r.s1_valid;
	assign f5_dump  = f5_integ && (r.f5_mcnt == f5_dec_eff);
	assign f5_in_i  = {{(F5_ACC_W-DATA_W){r.s1_i[DATA_W-1]}}, r.s1_i};
	assign f5_in_q  = {{(F5_ACC_W-DATA_W){r.s1_q[DATA_W-1]}}, r.s1_q};

	assign f5_res_valid_q = f5_res_valid;
	assign push      = go && f5_res_valid_q;
	assign push_data = {shift_sat(f5_res_i, f5_shift), shift_sat(f5_res_q, f5_shift)};

	assign idx       = avs_address[rccd_pkg::ADDR_W-1:2];
	assign wr_fire   = avs_write && r.ack;
	assign factor_wr = wr_fire && ((idx == rccd_pkg::IDX_RS_DEC) || (idx == rccd_pkg::IDX_RS_INT) ||
		(idx == rccd_pkg::IDX_F5_DEC));

	////////////////////////////////////////////////////////////////////////
	// Register read mux
	always_comb
	begin
		rd_mux = '0;
		case (idx)
			rccd_pkg::IDX_RS_DEC:   rd_mux[rccd_pkg::RS_DEC_W-1:0]   = r.rs_dec;
			rccd_pkg::IDX_RS_INT:   rd_mux[rccd_pkg::RS_INT_W-1:0]   = r.rs_int;
			rccd_pkg::IDX_RS_SCALE: rd_mux[rccd_pkg::RS_SCALE_W-1:0] = r.rs_scale;
			rccd_pkg::IDX_F5_DEC:   rd_mux[rccd_pkg::F5_DEC_W-1:0]   = r.f5_dec;
			rccd_pkg::IDX_F5_SCALE: rd_mux[rccd_pkg::SCALE_W-1:0]    = r.f5_scale;
			rccd_pkg::IDX_STATUS:   rd_mux[LW+2:0] = {buf_level, bypass, r.rs_state == rccd_pkg::RS_STUFF, buf_in_ready};
			default:                rd_mux = '0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		logic [BW-1:0] m;
		logic [DATA_W-1:0] src_i;
		logic [DATA_W-1:0] src_q;
		m = '0;
		src_i = '0;
		src_q = '0;
		next_r = r;

		// Bus: one wait cycle, read data captured then held for the answering edge
		next_r.ack = (avs_read || avs_write) && !r.ack;
		if (avs_read && !r.ack)
			next_r.rdata = rd_mux;

		if (go)
		begin
			// Resampling sequencer
			if (rs_integ)
				next_r.rs_mcnt = rs_dump ? '0 : r.rs_mcnt + 1'b1;
			case (r.rs_state)
				rccd_pkg::RS_IDLE:
				begin
					if (accept && !bypass && (r.rs_int != '0))
					begin
						next_r.rs_state  = rccd_pkg::RS_STUFF;
						next_r.stuff_cnt = r.rs_int;
					end
				end
				rccd_pkg::RS_STUFF:
				begin
					next_r.stuff_cnt = r.stuff_cnt - 1'b1;
					if (r.stuff_cnt == 9'h001)
						next_r.rs_state = rccd_pkg::RS_IDLE;
				end
				default:
					next_r.rs_state = rccd_pkg::RS_IDLE;
			endcase

			// Unfiltered path for ratio 1/1
			next_r.byp_valid = accept && bypass;
			next_r.byp_i = in_i;
			next_r.byp_q = in_q;

			// Stage one scaling applies in both paths
			if (r.byp_valid)
			begin
				src_i = shift_sat({{(F5_ACC_W-DATA_W){r.byp_i[DATA_W-1]}}, r.byp_i}, rs_shift);
				src_q = shift_sat({{(F5_ACC_W-DATA_W){r.byp_q[DATA_W-1]}}, r.byp_q}, rs_shift);
			end
			else
			begin
				src_i = shift_sat({rs_res_i[RS_ACC_W-1], rs_res_i}, rs_shift);
				src_q = shift_sat({rs_res_q[RS_ACC_W-1], rs_res_q}, rs_shift);
			end
			next_r.s1_valid = r.byp_valid || rs_res_valid_q;
			next_r.s1_i = src_i;
			next_r.s1_q = src_q;

			// Fifth-order decimation counter
			if (f5_integ)
				next_r.f5_mcnt = f5_dump ? '0 : r.f5_mcnt + 1'b1;
		end

		// Register writes; bits 11:10 of the scale word are not stored and read zero
		if (wr_fire)
		begin
			m = be_merge(rd_mux, avs_writedata, avs_byteenable);
			case (idx)
				rccd_pkg::IDX_RS_DEC:   next_r.rs_dec   = m[rccd_pkg::RS_DEC_W-1:0];
				rccd_pkg::IDX_RS_INT:   next_r.rs_int   = m[rccd_pkg::RS_INT_W-1:0];
				rccd_pkg::IDX_RS_SCALE: next_r.rs_scale = m[rccd_pkg::RS_SCALE_W-1:0];
				rccd_pkg::IDX_F5_DEC:   next_r.f5_dec   = m[rccd_pkg::F5_DEC_W-1:0];
				rccd_pkg::IDX_F5_SCALE: next_r.f5_scale = m[rccd_pkg::SCALE_W-1:0];
				default:                next_r.rdata    = r.rdata;
			endcase
		end

		// New rate factors restart the phase counters so no half-counted period survives
		if (factor_wr)
		begin
			next_r.rs_state  = rccd_pkg::RS_IDLE;
			next_r.stuff_cnt = '0;
			next_r.rs_mcnt   = '0;
			next_r.f5_mcnt   = '0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			r          <= '0;
			r.rs_dec   <= rccd_pkg::RS_DEC_RST;
			r.rs_int   <= rccd_pkg::RS_INT_RST;
			r.rs_scale <= rccd_pkg::RS_SCALE_RST;
			r.f5_dec   <= rccd_pkg::F5_DEC_RST;
			r.f5_scale <= rccd_pkg::F5_SCALE_RST;
		end
		else
			r <= next_r;
	end

	////////////////////////////////////////////////////////////////////////
	// Filter sections

	rccd_comb_core #(.ORDER(rccd_pkg::RS_ORDER), .W(RS_ACC_W)) u_rs_i (
		.clk       (clk),
		.rst_b     (rst_b),
		.advance   (go),
		.integ_en  (rs_integ),
		.dump_en   (rs_dump),
		.in_data   (rs_in_i),
		.res_valid (rs_res_valid),
		.res_data  (rs_res_i)
	);

	rccd_comb_core #(.ORDER(rccd_pkg::RS_ORDER), .W(RS_ACC_W)) u_rs_q (
		.clk       (clk),
		.rst_b     (rst_b),
		.advance   (go),
		.integ_en  (rs_integ),
		.dump_en   (rs_dump),
		.in_data   (rs_in_q),
		.res_valid (),
		.res_data  (rs_res_q)
	);

	rccd_comb_core #(.ORDER(rccd_pkg::F5_ORDER), .W(F5_ACC_W)) u_f5_i (
		.clk       (clk),
		.rst_b     (rst_b),
		.advance   (go),
		.integ_en  (f5_integ),
		.dump_en   (f5_dump),
		.in_data   (f5_in_i),
		.res_valid (f5_res_valid),
		.res_data  (f5_res_i)
	);

	rccd_comb_core #(.ORDER(rccd_pkg::F5_ORDER), .W(F5_ACC_W)) u_f5_q (
		.clk       (clk),
		.rst_b     (rst_b),
		.advance   (go),
		.integ_en  (f5_integ),
		.dump_en   (f5_dump),
		.in_data   (f5_in_q),
		.res_valid (),
		.res_data  (f5_res_q)
	);

	rccd_pair_buf #(.W(2*DATA_W), .DEPTH(rccd_pkg::BUF_DEPTH)) u_buf (
		.clk       (clk),
		.rst_b     (rst_b),
		.in_valid  (push),
		.in_ready  (buf_in_ready),
		.in_data   (push_data),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_data  (buf_out_data),
		.level     (buf_level)
	);

	assign out_i           = buf_out_data[2*DATA_W-1:DATA_W];
	assign out_q           = buf_out_data[DATA_W-1:0];
	assign avs_readdata    = r.rdata;
	assign avs_waitrequest = (avs_read || avs_write) && !r.ack;

endmodule
`default_nettype wire

// ==== test/rccd_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module rccd_monitor (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_b,
	// Register bus
	input wire logic [9:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// Streams
	input wire logic        in_valid,
	input wire logic        in_ready,
	input wire logic        out_valid,
	input wire logic        out_ready,
	input wire logic [15:0] out_i,
	input wire logic [15:0] out_q
);
	logic [7:0] idx;
	logic       rd_done;
	logic [8:0] interp_m1;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	assign idx = avs_address[9:2];
	assign rd_done = avs_read && !avs_waitrequest;

	// Shadow of interpolation, full-word writes only
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			interp_m1 <= 9'h000;
		else if (avs_write && !avs_waitrequest && idx == 8'h91 && avs_byteenable == 4'hF)
			interp_m1 <= avs_writedata[8:0];
	end

	////////////////////////////////////////
	a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("wait longer than one cycle");
	a_rd_dec: assert property (rd_done && idx == 8'h90 |-> avs_readdata[31:12] == 20'h00000)
		else $error("decimation read too wide");
	a_rd_interp: assert property (rd_done && idx == 8'h91 |-> avs_readdata[31:9] == 23'h000000)
		else $error("interpolation read too wide");
	a_rd_scale: assert property (rd_done && idx == 8'h92 |-> avs_readdata[31:10] == 22'h000000)
		else $error("scale read too wide");
	a_rd_unmap: assert property (rd_done && (idx < 8'h90 || idx > 8'h95) |-> avs_readdata == 32'h00000000)
		else $error("unmapped read not zero");
	a_rd_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
		else $error("read data changed without read");
	a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_i) && $stable(out_q))
		else $error("output word lost under stall");
	a_rst_clear: assert property ($rose(rst_b) |-> !out_valid && in_ready && avs_readdata == 32'h00000000)
		else $error("state after reset");
	a_stuff_gap: assert property (in_valid && in_ready && interp_m1 == 9'h001 |=> !in_ready)
		else $error("no stuffing cycle");
	c_stuff: cover property (in_valid && in_ready && interp_m1 != 9'h000);
	c_full: cover property (out_valid && !out_ready && !in_ready);
	c_read: cover property (rd_done && idx == 8'h92);
endmodule
bind rccd_top rccd_monitor mon_u (.clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
	.avs_byteenable, .avs_readdata, .avs_waitrequest, .in_valid, .in_ready, .out_valid, .out_ready,
	.out_i, .out_q);
`default_nettype wire

// ==== test/rccd_sink.sv ====
`timescale 1ns/10ps
`default_nettype none
module rccd_sink (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// Flow control
	input  wire logic hold,
	output logic      out_ready
);
	integer seed = 32'hD9CE;

	// Random back-pressure keeps the buffer busy
	always_ff @(posedge clk)
	begin
		if (!rst_b || hold)
			out_ready <= 1'b0;
		else
			out_ready <= ($random(seed) & 3) != 0;
	end
endmodule
`default_nettype wire

// ==== test/rccd_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module rccd_tb_top;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [9:0]  avs_address = 10'h000;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        in_valid = 1'b0;
	logic        in_ready;
	logic [15:0] in_i = 16'h0000;
	logic [15:0] in_q = 16'h0000;
	logic        out_valid;
	logic        out_ready;
	logic [15:0] out_i;
	logic [15:0] out_q;
	logic        hold = 1'b0;
	logic [32:0] exp_q[$];
	logic [32:0] note;
	logic [31:0] r;
	logic [31:0] t;
	integer      seed = 32'hD9CE;
	int          error_cnt = 0;
	int          compares = 0;
	int          cyc = 0;
	int          k;

	rccd_top dut_u (.clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
		.avs_readdata, .avs_waitrequest, .in_valid, .in_ready, .in_i, .in_q, .out_valid, .out_ready,
		.out_i, .out_q);
	rccd_sink sink_u (.clk, .rst_b, .hold, .out_ready);

	initial
	begin
		forever #2 clk = ~clk;
	end

	////////////////////////////////////////
	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask

	task automatic complete_run();
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic do_reset();
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
	endtask

	// Request held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d, input logic [3:0] be,
		output logic [31:0] rd);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_read <= !wr;
		avs_write <= wr;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic rd_chk(input logic [9:0] a, input logic [31:0] e);
		logic [31:0] v;
		bus(1'b0, a, 32'h00000000, 4'hF, v);
		check("readdata", e, v);
	endtask

	task automatic stall_release();
		repeat (160) @(posedge clk);
		check("in_ready full", 32'h00000000, {31'h0, in_ready});
		hold <= 1'b0;
	endtask

	// Constant complex input, ten outputs, first six left unchecked as transient
	task automatic run(input logic [11:0] dm, input logic [8:0] lm, input logic [4:0] s1, input logic [4:0] m5,
		input logic [4:0] s5, input logic [15:0] x, input logic [15:0] e);
		int j;
		int n_in;
		logic [31:0] w;
		do_reset();
		bus(1'b1, 10'h240, {20'h0, dm}, 4'hF, w);
		bus(1'b1, 10'h244, {23'h0, lm}, 4'hF, w);
		bus(1'b1, 10'h248, {22'h0, s1, s1}, 4'hF, w);
		bus(1'b1, 10'h24C, {27'h0, m5}, 4'hF, w);
		bus(1'b1, 10'h250, {27'h0, s5}, 4'hF, w);
		n_in = 10 * (dm + 1) * (m5 + 1) / (lm + 1);
		for (j = 0; j < 10; j++)
			exp_q.push_back({j >= 6, e, 16'h0000 - e});
		for (j = 0; j < n_in; j++)
		begin
			in_valid <= 1'b1;
			in_i <= x;
			in_q <= 16'h0000 - x;
			do @(posedge clk); while (in_ready !== 1'b1);
			if ($random(seed) % 4 == 0)
			begin
				in_valid <= 1'b0;
				@(posedge clk);
			end
		end
		in_valid <= 1'b0;
		for (j = 0; j < 3000 && exp_q.size() != 0; j++)
			@(posedge clk);
		repeat (40) @(posedge clk);
		check("notes left", 32'h00000000, exp_q.size());
	endtask

	////////////////////////////////////////
	always @(posedge clk)
	begin
		if (rst_b === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1)
		begin
			if (exp_q.size() == 0)
				check("spare output", 32'h00000000, 32'h00000001);
			else
			begin
				note = exp_q.pop_front();
				if (note[32])
				begin
					check("out_i", {16'h0000, note[31:16]}, {16'h0000, out_i});
					check("out_q", {16'h0000, note[15:0]}, {16'h0000, out_q});
				end
			end
		end
	end

	// Hang guard, far above the expected few thousand cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			error_cnt++;
			complete_run();
		end
	end

	initial
	begin
		do_reset();
		rd_chk(10'h240, 32'h00000000);
		rd_chk(10'h244, 32'h00000000);
		rd_chk(10'h248, 32'h00000000);
		rd_chk(10'h24C, 32'h00000001);
		rd_chk(10'h250, 32'h00000000);
		// Status after reset: bypass set, buffer empty with room
		rd_chk(10'h254, 32'h00000005);
		for (k = 0; k < 4; k++)
		begin
			r = $random(seed);
			bus(1'b1, 10'h240, r, 4'hF, t);
			rd_chk(10'h240, r & 32'h00000FFF);
			bus(1'b1, 10'h244, r, 4'hF, t);
			rd_chk(10'h244, r & 32'h000001FF);
			bus(1'b1, 10'h248, {22'h0, r[9:5], r[9:5]}, 4'hF, t);
			rd_chk(10'h248, {22'h0, r[9:5], r[9:5]});
			bus(1'b1, 10'h3FC, r, 4'hF, t);
			rd_chk(10'h3FC, 32'h00000000);
		end
		bus(1'b1, 10'h240, 32'hFFFFFFFF, 4'h2, t);
		rd_chk(10'h240, (r & 32'h000000FF) | 32'h00000F00);
		hold <= 1'b1;
		fork
			stall_release();
		join_none
		run(12'h000, 9'h000, 5'h02, 5'h01, 5'h00, 16'h0400, 16'h0100);
		run(12'h003, 9'h000, 5'h04, 5'h03, 5'h05, 16'h0300, 16'h0300);
		run(12'h003, 9'h001, 5'h03, 5'h1F, 5'h14, 16'hFE00, 16'hFE00);
		complete_run();
	end
endmodule
`default_nettype wire
